// *** logic/gxw_pkg.sv ***
// package: constants, types and decode helpers for the interrupt and wake pin selector
// Notes on behaviour
// (RULE1) Each external interrupt line has a 5-bit field in bits 4..0 that picks one of the 32 port A pins.
// (RULE2) After reset every select field holds 00000, so pin 0 drives each line.
// (RULE3) The select field is a plain binary pin index, 11110 picks pin 30 and 11111 picks pin 31.
// (RULE4) There are three independent lines, each with its own select register.
// (RULE5) The signal picked for line 2 also starts a conversion, but only while the converter enables that trigger.
// (RULE6) The conversion start taken from line 2 always reacts to rising edges, whatever the line's polarity.
// (RULE7) The wake mask holds 32 bits, bit n deciding whether port A pin n may wake the device.
// (RULE8) A pin whose mask bit is 0 has no effect on the device in halt or standby mode.
// (RULE9) A pin whose mask bit is 1 can wake the device from both halt and standby mode.
// (RULE10) Writes to the select and mask registers are ignored until the unlock instruction runs; reads always work.
// (RULE11) After the relock instruction, writes to those registers are ignored again.
// (RULE12) Reset clears the write permission, so protection is active from reset.
// (RULE13) The wake mask resets to all zeros, so no pin wakes the device until software allows it.
// (RULE14) The reserved upper bits of a select register read as zero and ignore writes.
package gxw_pkg;

   // sizes
   localparam int GXW_NUM_LINES = 3;
   localparam int GXW_PIN_COUNT = 32;
   localparam int GXW_SEL_W = 5;
   localparam int GXW_ADDR_W = 12;
   localparam int GXW_DATA_W = 32;
   localparam int GXW_IRQ_W = 3;

   // register byte offsets
   localparam logic [11:0] GXW_OFF_SEL1 = 12'h000;
   localparam logic [11:0] GXW_OFF_SEL2 = 12'h004;
   localparam logic [11:0] GXW_OFF_SEL3 = 12'h008;
   localparam logic [11:0] GXW_OFF_WAKE = 12'h00c;
   localparam logic [11:0] GXW_OFF_PROT = 12'h010;
   localparam logic [11:0] GXW_OFF_ISTAT = 12'h014;
   localparam logic [11:0] GXW_OFF_IEN = 12'h018;
   localparam logic [11:0] GXW_OFF_ICLR = 12'h01c;

   // reset values
   localparam logic [4:0] GXW_SEL_RESET = 5'h00;
   localparam logic [31:0] GXW_MASK_RESET = 32'h0000_0000;
   localparam logic [2:0] GXW_IRQ_RESET = 3'h0;

   // field positions
   localparam int GXW_PROT_BIT = 0;
   localparam int GXW_IRQ_REJECT = 0;
   localparam int GXW_IRQ_WAKE = 1;
   localparam int GXW_IRQ_CONV = 2;

   // line that doubles as conversion trigger (second line)
   localparam int GXW_CONV_LINE = 1;

   typedef enum logic [3:0] {
      GXW_REG_SEL1 = 4'h0,
      GXW_REG_SEL2 = 4'h1,
      GXW_REG_SEL3 = 4'h2,
      GXW_REG_WAKE = 4'h3,
      GXW_REG_PROT = 4'h4,
      GXW_REG_ISTAT = 4'h5,
      GXW_REG_IEN = 4'h6,
      GXW_REG_ICLR = 4'h7,
      GXW_REG_NONE = 4'hf
   } gxw_reg_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } gxw_apb_req_type;

   typedef struct packed {
      logic halt;
      logic standby;
   } gxw_lpm_type;

   // address decode, used for reads and writes
   function automatic gxw_reg_type gxw_decode(input logic [11:0] addr);
      unique case (addr)
         GXW_OFF_SEL1: gxw_decode = GXW_REG_SEL1;
         GXW_OFF_SEL2: gxw_decode = GXW_REG_SEL2;
         GXW_OFF_SEL3: gxw_decode = GXW_REG_SEL3;
         GXW_OFF_WAKE: gxw_decode = GXW_REG_WAKE;
         GXW_OFF_PROT: gxw_decode = GXW_REG_PROT;
         GXW_OFF_ISTAT: gxw_decode = GXW_REG_ISTAT;
         GXW_OFF_IEN: gxw_decode = GXW_REG_IEN;
         GXW_OFF_ICLR: gxw_decode = GXW_REG_ICLR;
         default: gxw_decode = GXW_REG_NONE;
      endcase
   endfunction

   // byte-lane merge of write data into an old value
   function automatic logic [31:0] gxw_merge(input logic [31:0] old, input logic [31:0] wdata,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = wdata[8*b +: 8];
         end
      end
      return res;
   endfunction

endpackage

// *** logic/gxw_sync.sv ***
// two flip-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
module gxw_sync #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // levels
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_reg;

   // first stage is read only by the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q_out <= '0;
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule

// *** logic/gxw_pin_mux.sv ***
// one-of-n pin selector with registered output
`timescale 1ns/10ps
module gxw_pin_mux #(
   parameter int PINS = 32,
   parameter int SEL_W = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins and select
   input wire logic [PINS-1:0] pins,
   input wire logic [SEL_W-1:0] sel,
   // selected line
   output logic line_out
);
   // plain binary index into the pin vector
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_out <= 1'b0;
      end else begin
         line_out <= pins[sel]; // see (RULE3)
      end
   end
endmodule

// *** logic/gxw_top.sv ***
// external interrupt pin select, wake mask and protected register file behind apb
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module gxw_top
   import gxw_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RSTN,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [GXW_ADDR_W-1:0] PADDR,
   input wire logic [GXW_DATA_W-1:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic PREADY,
   output logic [GXW_DATA_W-1:0] PRDATA,
   output logic PSLVERR,
   // protected write control from the cpu
   input wire logic PROT_UNLOCK,
   input wire logic PROT_RELOCK,
   // port a pins
   input wire logic [GXW_PIN_COUNT-1:0] GPIO_A_IN,
   // converter trigger
   input wire logic CONV_TRIG_ENABLE,
   output logic CONV_START_TRIGGER,
   // low power mode
   input wire logic LPM_HALT,
   input wire logic LPM_STANDBY,
   output logic LPM_WAKE,
   // interrupt lines and block interrupt
   output logic [GXW_NUM_LINES-1:0] EXT_IRQ_LINE,
   output logic IRQ
);

   gxw_apb_req_type req;
   gxw_lpm_type lpm;
   gxw_reg_type reg_sel;
   logic setup_phase;
   logic acc_phase;
   logic wr_acc;
   logic prot_hit;
   logic wr_ok;
   logic wr_reject;
   logic permit_reg;
   logic [GXW_SEL_W-1:0] sel_reg [GXW_NUM_LINES];
   logic [GXW_PIN_COUNT-1:0] mask_reg;
   logic [GXW_PIN_COUNT-1:0] pin_sync;
   logic [GXW_NUM_LINES-1:0] line_vec;
   logic conv_line_d_reg;
   logic conv_reg;
   logic lpm_active;
   logic wake_next;
   logic wake_reg;
   logic [GXW_IRQ_W-1:0] irq_stat_reg;
   logic [GXW_IRQ_W-1:0] irq_en_reg;
   logic [GXW_IRQ_W-1:0] irq_evt;
   logic [GXW_IRQ_W-1:0] irq_clr;
   logic [GXW_DATA_W-1:0] rd_value;
   logic [GXW_DATA_W-1:0] prdata_reg;
   logic [GXW_DATA_W-1:0] merged;

   // bus request and low power mode as carriers
   assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA, pstrb: PSTRB};
   assign lpm = '{halt: LPM_HALT, standby: LPM_STANDBY};

   // apb phase decode
   assign reg_sel = gxw_decode(req.paddr);
   assign setup_phase = req.psel & ~req.penable;
   assign acc_phase = req.psel & req.penable;
   assign wr_acc = acc_phase & req.pwrite;
   assign merged = gxw_merge(rd_value, req.pwdata, req.pstrb);

   // protected registers accept writes only while permission is open
   assign prot_hit = (reg_sel == GXW_REG_SEL1) || (reg_sel == GXW_REG_SEL2) ||
                     (reg_sel == GXW_REG_SEL3) || (reg_sel == GXW_REG_WAKE);
   assign wr_ok = wr_acc & prot_hit & permit_reg; // see (RULE10)
   assign wr_reject = wr_acc & prot_hit & ~permit_reg; // see (RULE10)

   // zero wait slave: ready in every access phase, error on unmapped address
   assign PREADY = acc_phase;
   assign PSLVERR = acc_phase & (reg_sel == GXW_REG_NONE);

   // write permission: relock wins over a same-cycle unlock
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         permit_reg <= 1'b0; // see (RULE12)
      end else if (PROT_RELOCK) begin
         permit_reg <= 1'b0; // see (RULE11)
      end else if (PROT_UNLOCK) begin
         permit_reg <= 1'b1; // see (RULE10)
      end
   end

   // per-line select fields, bits 4..0 only, upper bits dropped
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < GXW_NUM_LINES; i++) begin
            sel_reg[i] <= GXW_SEL_RESET; // see (RULE2)
         end
      end else begin
         for (int i = 0; i < GXW_NUM_LINES; i++) begin
            if (wr_ok && (reg_sel == gxw_reg_type'(4'(i)))) begin
               sel_reg[i] <= merged[GXW_SEL_W-1:0]; // see (RULE1) see (RULE14)
            end
         end
      end
   end

   // wake mask, one bit per port a pin
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         mask_reg <= GXW_MASK_RESET; // see (RULE13)
      end else if (wr_ok && (reg_sel == GXW_REG_WAKE)) begin
         mask_reg <= merged; // see (RULE7)
      end
   end

   // pins are asynchronous, synchronise before any use
   gxw_sync #(
      .WIDTH(GXW_PIN_COUNT)
   ) u_pin_sync (
      .clk(CLK_SYS),
      .rst_n(RSTN),
      .d_in(GPIO_A_IN),
      .q_out(pin_sync)
   );

   // one independent selector per external interrupt line
   for (genvar g = 0; g < GXW_NUM_LINES; g++) begin : g_line
      gxw_pin_mux #(
         .PINS(GXW_PIN_COUNT),
         .SEL_W(GXW_SEL_W)
      ) u_mux (
         .clk(CLK_SYS),
         .rst_n(RSTN),
         .pins(pin_sync),
         .sel(sel_reg[g]),
         .line_out(line_vec[g]) // see (RULE4)
      );
   end
   assign EXT_IRQ_LINE = line_vec;

   // conversion start: rising edge of line 2, gated by the converter's enable
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         conv_line_d_reg <= 1'b0;
         conv_reg <= 1'b0;
      end else begin
         conv_line_d_reg <= line_vec[GXW_CONV_LINE];
         conv_reg <= CONV_TRIG_ENABLE & line_vec[GXW_CONV_LINE] & ~conv_line_d_reg; // see (RULE5) see (RULE6)
      end
   end
   assign CONV_START_TRIGGER = conv_reg;

   // wake request only from masked pins and only in halt or standby
   assign lpm_active = lpm.halt | lpm.standby;
   assign wake_next = lpm_active & (|(pin_sync & mask_reg)); // see (RULE8) see (RULE9)
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= wake_next;
      end
   end
   assign LPM_WAKE = wake_reg;

   // interrupt events and write-one-to-clear requests
   always_comb begin
      irq_evt = GXW_IRQ_RESET;
      irq_evt[GXW_IRQ_REJECT] = wr_reject;
      irq_evt[GXW_IRQ_WAKE] = wake_next & ~wake_reg;
      irq_evt[GXW_IRQ_CONV] = conv_reg;
   end
   assign irq_clr = (wr_acc && (reg_sel == GXW_REG_ICLR) && req.pstrb[0]) ?
                    req.pwdata[GXW_IRQ_W-1:0] : GXW_IRQ_RESET;

   // sticky status, a new event wins over a clear in the same cycle
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         irq_stat_reg <= GXW_IRQ_RESET;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
      end
   end

   // interrupt enable register, not protected
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         irq_en_reg <= GXW_IRQ_RESET;
      end else if (wr_acc && (reg_sel == GXW_REG_IEN)) begin
         irq_en_reg <= merged[GXW_IRQ_W-1:0];
      end
   end
   assign IRQ = |(irq_stat_reg & irq_en_reg);

   // read value, reserved bits are zero
   always_comb begin
      rd_value = '0;
      unique case (reg_sel)
         GXW_REG_SEL1: rd_value = 32'(sel_reg[0]); // see (RULE14)
         GXW_REG_SEL2: rd_value = 32'(sel_reg[1]);
         GXW_REG_SEL3: rd_value = 32'(sel_reg[2]);
         GXW_REG_WAKE: rd_value = mask_reg;
         GXW_REG_PROT: rd_value[GXW_PROT_BIT] = permit_reg;
         GXW_REG_ISTAT: rd_value = 32'(irq_stat_reg);
         GXW_REG_IEN: rd_value = 32'(irq_en_reg);
         GXW_REG_ICLR: rd_value = '0;
         GXW_REG_NONE: rd_value = '0;
      endcase
   end

   // read data captured in the setup phase, reads never blocked
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         prdata_reg <= '0;
      end else if (setup_phase && !req.pwrite) begin
         prdata_reg <= rd_value; // see (RULE10)
      end
   end
   assign PRDATA = prdata_reg;

   // checks on select fields, conversion start, wake mask and write protection
   property p_sel_write;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (wr_ok && reg_sel == GXW_REG_SEL1 && req.pstrb[0]) |=> (sel_reg[0] == $past(req.pwdata[4:0]));
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("select field not loaded from bits 4..0"); // see (RULE1)

   property p_sel_reset;
      @(posedge CLK_SYS) $rose(RSTN) |-> (sel_reg[0] == 5'h00 && sel_reg[1] == 5'h00 && sel_reg[2] == 5'h00);
   endproperty
   a_sel_reset: assert property (p_sel_reset) else $error("select fields not zero after reset"); // see (RULE2)

   property p_line_index;
      @(posedge CLK_SYS) disable iff (!RSTN)
      ##1 (EXT_IRQ_LINE[2] == $past(pin_sync[sel_reg[2]]));
   endproperty
   a_line_index: assert property (p_line_index) else $error("line 3 does not follow the indexed pin"); // see (RULE3)

   property p_conv_gate;
      @(posedge CLK_SYS) disable iff (!RSTN)
      CONV_START_TRIGGER |-> $past(CONV_TRIG_ENABLE);
   endproperty
   a_conv_gate: assert property (p_conv_gate) else $error("conversion start without enable"); // see (RULE5)

   property p_conv_rise;
      @(posedge CLK_SYS) disable iff (!RSTN)
      CONV_START_TRIGGER |-> ($past(EXT_IRQ_LINE[1]) && !$past(EXT_IRQ_LINE[1], 2));
   endproperty
   a_conv_rise: assert property (p_conv_rise) else $error("conversion start not on a rising edge"); // see (RULE6)

   property p_conv_fire;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (CONV_TRIG_ENABLE && $rose(EXT_IRQ_LINE[1])) |=> CONV_START_TRIGGER;
   endproperty
   a_conv_fire: assert property (p_conv_fire) else $error("enabled rising edge lost"); // see (RULE6)

   property p_wake_masked;
      @(posedge CLK_SYS) disable iff (!RSTN)
      LPM_WAKE |-> $past((LPM_HALT || LPM_STANDBY) && ((pin_sync & mask_reg) != 32'h0000_0000));
   endproperty
   a_wake_masked: assert property (p_wake_masked) else $error("wake from an unmasked pin"); // see (RULE8)

   property p_wake_fire;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (LPM_STANDBY && (pin_sync & mask_reg) != 32'h0000_0000) |=> LPM_WAKE;
   endproperty
   a_wake_fire: assert property (p_wake_fire) else $error("enabled pin failed to wake"); // see (RULE9)

   property p_locked_hold;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (wr_acc && !permit_reg && reg_sel == GXW_REG_WAKE) |=> $stable(mask_reg);
   endproperty
   a_locked_hold: assert property (p_locked_hold) else $error("locked write changed the wake mask"); // see (RULE10)

   property p_relock;
      @(posedge CLK_SYS) disable iff (!RSTN)
      PROT_RELOCK |=> (!permit_reg && !wr_ok);
   endproperty
   a_relock: assert property (p_relock) else $error("write permitted after relock"); // see (RULE11)

   property p_reset_state;
      @(posedge CLK_SYS) $rose(RSTN) |-> (!permit_reg && mask_reg == 32'h0000_0000);
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("permission or mask not clear after reset"); // see (RULE12) see (RULE13)

   property p_reserved_zero;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (setup_phase && !req.pwrite && reg_sel == GXW_REG_SEL2) |=> (PRDATA[31:5] == 27'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved select bits not zero"); // see (RULE14)

   // checks on the other two selectors and the trigger pulse
   property p_line1_index;
      @(posedge CLK_SYS) disable iff (!RSTN)
      ##1 (EXT_IRQ_LINE[0] == $past(pin_sync[sel_reg[0]]));
   endproperty
   a_line1_index: assert property (p_line1_index) else $error("line 1 does not follow the indexed pin"); // see (RULE3)

   property p_line2_index;
      @(posedge CLK_SYS) disable iff (!RSTN)
      ##1 (EXT_IRQ_LINE[1] == $past(pin_sync[sel_reg[1]]));
   endproperty
   a_line2_index: assert property (p_line2_index) else $error("line 2 does not follow the indexed pin"); // see (RULE4)

   property p_conv_pulse;
      @(posedge CLK_SYS) disable iff (!RSTN)
      CONV_START_TRIGGER |=> !CONV_START_TRIGGER;
   endproperty
   a_conv_pulse: assert property (p_conv_pulse) else $error("conversion start longer than one cycle"); // see (RULE6)

   // checks on the wake path
   property p_wake_halt;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (LPM_HALT && (pin_sync & mask_reg) != GXW_MASK_RESET) |=> LPM_WAKE;
   endproperty
   a_wake_halt: assert property (p_wake_halt) else $error("enabled pin failed to wake from halt"); // see (RULE9)

   property p_wake_none;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (mask_reg == GXW_MASK_RESET) |=> !LPM_WAKE;
   endproperty
   a_wake_none: assert property (p_wake_none) else $error("wake with an empty mask"); // see (RULE8)

   property p_mask_write;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (wr_ok && reg_sel == GXW_REG_WAKE && req.pstrb == 4'hf) |=> (mask_reg == $past(req.pwdata));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("wake mask not loaded"); // see (RULE7)

   // checks on write permission
   property p_unlock;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (PROT_UNLOCK && !PROT_RELOCK) |=> permit_reg;
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock did not open writes"); // see (RULE10)

   property p_locked_sel;
      @(posedge CLK_SYS) disable iff (!RSTN)
      wr_reject |=> ($stable(sel_reg[0]) && $stable(sel_reg[1]) && $stable(sel_reg[2]));
   endproperty
   a_locked_sel: assert property (p_locked_sel) else $error("locked write changed a select field"); // see (RULE10)

   property p_read_open;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (setup_phase && !req.pwrite && reg_sel == GXW_REG_WAKE) |=> (PRDATA == $past(mask_reg));
   endproperty
   a_read_open: assert property (p_read_open) else $error("wake mask read blocked"); // see (RULE10)

endmodule

// *** tb/gxw_lpm_model.sv ***
// low-power mode controller model: enters a mode on request, leaves it on wake
`timescale 1ns/10ps
module gxw_lpm_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // mode requests and wake from the block
   input wire logic go_halt,
   input wire logic go_standby,
   input wire logic wake,
   // mode levels to the block
   output logic halt,
   output logic standby
);
   // a wake in either mode ends it, a request enters it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         halt <= 1'b0;
         standby <= 1'b0;
      end else if (wake && (halt || standby)) begin
         halt <= 1'b0;
         standby <= 1'b0;
      end else begin
         halt <= halt | go_halt;
         standby <= standby | go_standby;
      end
   end
endmodule

// *** tb/gxw_top_test.sv ***
// self-checking bench for the interrupt pin select and wake mask block
`timescale 1ns/10ps
module gxw_top_test;
   import gxw_pkg::*;

   // stimulus, responses and bookkeeping
   logic clk, rst_n, psel, penable, pwrite, unlock, relock, conv_en, go_halt, go_standby;
   logic pready, pslverr, conv_trig, wake, irq, halt, standby, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, gpio, prdata, d, r;
   logic [2:0] lines;
   logic [4:0] selv [3];
   int errors, checks, cycles, n, seed;

   // design and far-side model
   gxw_top u_dut (
      .CLK_SYS(clk), .RSTN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PSTRB(4'hf), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .PROT_UNLOCK(unlock), .PROT_RELOCK(relock), .GPIO_A_IN(gpio), .CONV_TRIG_ENABLE(conv_en),
      .CONV_START_TRIGGER(conv_trig), .LPM_HALT(halt), .LPM_STANDBY(standby), .LPM_WAKE(wake),
      .EXT_IRQ_LINE(lines), .IRQ(irq)
   );
   gxw_lpm_model u_lpm (
      .clk(clk), .rst_n(rst_n), .go_halt(go_halt), .go_standby(go_standby), .wake(wake),
      .halt(halt), .standby(standby)
   );

   // clock and hang guard
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         wrap_up();
      end
   end

   // expected select readback: upper bits read zero
   function automatic logic [31:0] exp_sel(input logic [31:0] w);
      return {27'h0, w[4:0]};
   endfunction

   // expected interrupt line level for a pin index
   function automatic logic exp_line(input logic [31:0] g, input logic [4:0] s);
      return g[s];
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] x;
      logic y;
      apb(1'b1, a, wd, x, y);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] x;
      logic y;
      apb(1'b0, a, 32'h0, x, y);
      check(x, exp, "read data");
   endtask

   // one-cycle unlock or relock pulse
   task automatic lock(input logic open);
      @(posedge clk);
      unlock <= open;
      relock <= !open;
      @(posedge clk);
      unlock <= 1'b0;
      relock <= 1'b0;
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic count_trig(output int c);
      c = 0;
      repeat (8) begin
         @(posedge clk);
         #1;
         if (conv_trig === 1'b1) c++;
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {psel, penable, pwrite, unlock, relock, conv_en, go_halt, go_standby} = 8'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      gpio = 32'h0;
      seed = $urandom(9);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) rd(12'(4 * i), 32'h0);
      rd(GXW_OFF_PROT, 32'h0);
      // locked write is dropped and raises the reject interrupt
      wr(GXW_OFF_IEN, 32'h7);
      wr(GXW_OFF_SEL1, 32'h1f);
      rd(GXW_OFF_SEL1, 32'h0);
      rd(GXW_OFF_ISTAT, 32'h1);
      check(32'(irq), 32'h1, "irq raised");
      wr(GXW_OFF_IEN, 32'h0);
      rd(GXW_OFF_ISTAT, 32'h1);
      check(32'(irq), 32'h0, "irq masked");
      wr(GXW_OFF_ICLR, 32'h7);
      rd(GXW_OFF_ISTAT, 32'h0);
      rd(GXW_OFF_ICLR, 32'h0);
      lock(1'b1);
      rd(GXW_OFF_PROT, 32'h1);
      // select rounds, the first on pins 30 and 31
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 3; i++) begin
            d = $urandom;
            if (k == 0) d[4:0] = 5'h1e + 5'(i % 2);
            selv[i] = d[4:0];
            wr(12'(4 * i), d);
            rd(12'(4 * i), exp_sel(d));
         end
         @(posedge clk);
         gpio <= (k == 0) ? 32'h4000_0000 : $urandom;
         settle(5);
         for (int i = 0; i < 3; i++) check(32'(lines[i]), 32'(exp_line(gpio, selv[i])), "line");
      end
      // conversion start: rise with enable, fall, rise without enable
      wr(GXW_OFF_SEL2, 32'h7);
      @(posedge clk);
      gpio <= 32'h0;
      settle(5);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         conv_en <= (k < 2);
         gpio[7] <= (k != 1);
         count_trig(n);
         check(32'(n), 32'(k == 0), "start pulses");
      end
      // wake from halt then standby: unmasked pin ignored, masked pin wakes
      d = ($urandom & ~32'h0000_0200) | 32'h0000_0010;
      wr(GXW_OFF_WAKE, d);
      rd(GXW_OFF_WAKE, d);
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         gpio <= 32'h0;
         repeat (4) @(posedge clk);
         go_halt <= (m == 0);
         go_standby <= (m == 1);
         @(posedge clk);
         go_halt <= 1'b0;
         go_standby <= 1'b0;
         gpio[9] <= 1'b1;
         settle(6);
         check(32'({wake, halt, standby}), 32'(m == 0 ? 2 : 1), "unmasked pin");
         @(posedge clk);
         gpio[4] <= 1'b1;
         settle(6);
         check(32'({halt, standby}), 32'h0, "masked pin wakes");
      end
      // wake and conversion events both left sticky status bits
      rd(GXW_OFF_ISTAT, 32'h6);
      // relock, then an unmapped access
      lock(1'b0);
      rd(GXW_OFF_PROT, 32'h0);
      wr(GXW_OFF_WAKE, ~d);
      rd(GXW_OFF_WAKE, d);
      rd(GXW_OFF_ISTAT, 32'h7);
      apb(1'b0, 12'h020, 32'h0, r, e);
      check(r, 32'h0, "unmapped data");
      check(32'(e), 32'h1, "unmapped error");
      wrap_up();
   end
endmodule
